//--- verilog/ptcc_time_clock_ctrl.sv
// Precision time clock with control, holding, step, load and rate adjustment registers
// Overview of operation
// - Setting bit 15 stops switch timers, shapers and policers from following clock rate corrections.
// - Writing 1 to bit 6 applies the held nanosecond value once to the clock, then the bit clears.
// - Bit 5 picks the step sign: 1 adds the held value, 0 subtracts it.
// - Writing 1 to bit 4 copies the clock into the nanosecond and second holding words and zeroes the phase word, then clears.
// - Writing 1 to bit 3 loads the clock from the holding words, then the bit clears.
// - While bit 2 is 1 the fractional rate value is applied to the clock on every 25 MHz cycle in which it advances.
// - Bit 1 lets the clock advance when 1 and stops it when 0, and resets to 0.
// - Writing 1 to bit 0 resets the clock, then the bit clears.
// - The rate sign bit adds the fractional rate when 1 and subtracts it when 0.
// - The 3-bit phase names one of five 8 ns sub-phases; values 5 to 7 are invalid.
// - The 32-bit nanosecond value is held as a high and a low 16-bit word.
// - The 32-bit seconds value is held as a high and a low 16-bit word.
`timescale 1ns/1ps
`default_nettype none
module ptcc_time_clock_ctrl (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	output logic             reg_rdata_valid,
	output logic      [31:0] rtc_sec,
	output logic      [31:0] rtc_ns,
	output logic             rtc_tick,
	output logic             freq_corr_follow
);
	// Control bits
	logic freq_dis_ff, nxt_freq_dis;
	logic step_ff, nxt_step;
	logic step_dir_ff, nxt_step_dir;
	logic snap_ff, nxt_snap;
	logic load_ff, nxt_load;
	logic cont_adj_ff, nxt_cont_adj;
	logic enable_ff, nxt_enable;
	logic clr_ff, nxt_clr;
	// Holding and rate registers
	logic [2:0]  h_phase_ff, nxt_h_phase;
	logic [31:0] h_ns_ff, nxt_h_ns;
	logic [31:0] h_sec_ff, nxt_h_sec;
	logic        rate_sign_ff, nxt_rate_sign;
	logic        temp_adj_ff, nxt_temp_adj;
	logic [ptcc_pkg::RATE_W-1:0] rate_ff, nxt_rate;
	// Running clock
	logic [31:0] sec_ff, nxt_sec;
	logic [31:0] ns_ff, nxt_ns;
	logic [ptcc_pkg::RATE_W-1:0] frac_ff, nxt_frac;
	logic        div_ff, nxt_div;
	logic [15:0] rdata_ff, nxt_rdata;
	logic        rvalid_ff, nxt_rvalid;
	logic        tick_out_ff, nxt_tick_out;
	logic        follow_ff, nxt_follow;

	logic        tick;
	logic [ptcc_pkg::RATE_W:0] frac_sum;
	logic [ptcc_pkg::RATE_W:0] frac_diff;
	logic [31:0] adv_delta;
	logic [31:0] adv_sec, adv_ns, step_sec, step_ns;

	assign tick = div_ff == 1'b1;

	// Per-tick advance: nominal period plus one ns on fractional carry, minus one ns on borrow
	always_comb begin
		frac_sum  = {1'b0, frac_ff} + {1'b0, rate_ff};
		frac_diff = {1'b0, frac_ff} - {1'b0, rate_ff};
		adv_delta = ptcc_pkg::NS_PER_TICK;
		if (cont_adj_ff) begin
			if (rate_sign_ff && frac_sum[ptcc_pkg::RATE_W]) begin
				adv_delta = ptcc_pkg::NS_PER_TICK + 32'h0000_0001;
			end else if (!rate_sign_ff && frac_diff[ptcc_pkg::RATE_W]) begin
				adv_delta = ptcc_pkg::NS_PER_TICK - 32'h0000_0001;
			end
		end
	end

	ptcc_time_add u_adv (
		.sec_in  (sec_ff),
		.ns_in   (ns_ff),
		.delta   (adv_delta),
		.add     (1'b1),
		.sec_out (adv_sec),
		.ns_out  (adv_ns)
	);

	ptcc_time_add u_step (
		.sec_in  (sec_ff),
		.ns_in   (ns_ff),
		.delta   (h_ns_ff),
		.add     (step_dir_ff),
		.sec_out (step_sec),
		.ns_out  (step_ns)
	);

	// Register writes and reads
	always_comb begin
		nxt_freq_dis  = freq_dis_ff;
		nxt_step      = step_ff;
		nxt_step_dir  = step_dir_ff;
		nxt_snap      = snap_ff;
		nxt_load      = load_ff;
		nxt_cont_adj  = cont_adj_ff;
		nxt_enable    = enable_ff;
		nxt_clr       = clr_ff;
		nxt_h_phase   = h_phase_ff;
		nxt_h_ns      = h_ns_ff;
		nxt_h_sec     = h_sec_ff;
		nxt_rate_sign = rate_sign_ff;
		nxt_temp_adj  = temp_adj_ff;
		nxt_rate      = rate_ff;
		nxt_rdata     = rdata_ff;
		nxt_rvalid    = reg_rd;
		// Actions run on the next reference tick; a fresh write in that cycle re-arms
		if (tick) begin
			nxt_clr  = 1'b0;
			nxt_load = 1'b0;
			nxt_step = 1'b0;
			nxt_snap = 1'b0;
			if (snap_ff) begin
				nxt_h_phase = 3'h0;
				nxt_h_ns    = ns_ff;
				nxt_h_sec   = sec_ff;
			end
		end
		if (reg_wr) begin
			case (reg_addr)
				ptcc_pkg::ADDR_CTRL: begin
					nxt_freq_dis = reg_wdata[ptcc_pkg::BIT_FREQ_DIS];
					nxt_step_dir = reg_wdata[ptcc_pkg::BIT_STEP_DIR];
					nxt_cont_adj = reg_wdata[ptcc_pkg::BIT_CONT_ADJ];
					nxt_enable   = reg_wdata[ptcc_pkg::BIT_ENABLE];
					nxt_snap     = reg_wdata[ptcc_pkg::BIT_SNAP] | nxt_snap;
					nxt_load     = reg_wdata[ptcc_pkg::BIT_LOAD] | nxt_load;
					nxt_clr      = reg_wdata[ptcc_pkg::BIT_RESET] | nxt_clr;
					nxt_step     = reg_wdata[ptcc_pkg::BIT_STEP] | (tick ? 1'b0 : step_ff);
				end
				ptcc_pkg::ADDR_PHASE: begin
					if (reg_wdata[ptcc_pkg::PHASE_W-1:0] <= ptcc_pkg::PHASE_MAX) begin
						nxt_h_phase = reg_wdata[ptcc_pkg::PHASE_W-1:0];
					end
				end
				ptcc_pkg::ADDR_NS_HI:  nxt_h_ns[31:16]  = reg_wdata;
				ptcc_pkg::ADDR_NS_LO:  nxt_h_ns[15:0]   = reg_wdata;
				ptcc_pkg::ADDR_SEC_HI: nxt_h_sec[31:16] = reg_wdata;
				ptcc_pkg::ADDR_SEC_LO: nxt_h_sec[15:0]  = reg_wdata;
				ptcc_pkg::ADDR_RATE_HI: begin
					nxt_rate_sign = reg_wdata[ptcc_pkg::BIT_RATE_SIGN];
					nxt_temp_adj  = reg_wdata[ptcc_pkg::BIT_TEMP_ADJ];
					nxt_rate[ptcc_pkg::RATE_W-1:16] = reg_wdata[ptcc_pkg::RATE_HI_W-1:0];
				end
				ptcc_pkg::ADDR_RATE_LO: nxt_rate[15:0] = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			nxt_rdata = ptcc_pkg::RESET_WORD;
			case (reg_addr)
				ptcc_pkg::ADDR_CTRL: begin
					nxt_rdata[ptcc_pkg::BIT_FREQ_DIS] = freq_dis_ff;
					nxt_rdata[ptcc_pkg::BIT_STEP]     = step_ff;
					nxt_rdata[ptcc_pkg::BIT_STEP_DIR] = step_dir_ff;
					nxt_rdata[ptcc_pkg::BIT_SNAP]     = snap_ff;
					nxt_rdata[ptcc_pkg::BIT_LOAD]     = load_ff;
					nxt_rdata[ptcc_pkg::BIT_CONT_ADJ] = cont_adj_ff;
					nxt_rdata[ptcc_pkg::BIT_ENABLE]   = enable_ff;
					nxt_rdata[ptcc_pkg::BIT_RESET]    = clr_ff;
				end
				ptcc_pkg::ADDR_PHASE:  nxt_rdata[ptcc_pkg::PHASE_W-1:0] = h_phase_ff;
				ptcc_pkg::ADDR_NS_HI:  nxt_rdata = h_ns_ff[31:16];
				ptcc_pkg::ADDR_NS_LO:  nxt_rdata = h_ns_ff[15:0];
				ptcc_pkg::ADDR_SEC_HI: nxt_rdata = h_sec_ff[31:16];
				ptcc_pkg::ADDR_SEC_LO: nxt_rdata = h_sec_ff[15:0];
				ptcc_pkg::ADDR_RATE_HI: begin
					nxt_rdata[ptcc_pkg::BIT_RATE_SIGN] = rate_sign_ff;
					nxt_rdata[ptcc_pkg::BIT_TEMP_ADJ]  = temp_adj_ff;
					nxt_rdata[ptcc_pkg::RATE_HI_W-1:0] = rate_ff[ptcc_pkg::RATE_W-1:16];
				end
				ptcc_pkg::ADDR_RATE_LO: nxt_rdata = rate_ff[15:0];
				default: nxt_rdata = ptcc_pkg::RESET_WORD;
			endcase
		end
	end

	// Running clock update, priority reset, load, step, then advance
	always_comb begin
		nxt_div      = ~div_ff;
		nxt_sec      = sec_ff;
		nxt_ns       = ns_ff;
		nxt_frac     = frac_ff;
		nxt_tick_out = tick & enable_ff;
		nxt_follow   = ~freq_dis_ff;
		if (tick) begin
			if (clr_ff) begin
				nxt_sec  = 32'h0000_0000;
				nxt_ns   = 32'h0000_0000;
				nxt_frac = '0;
			end else if (load_ff) begin
				nxt_sec = h_sec_ff;
				nxt_ns  = h_ns_ff;
			end else if (step_ff) begin
				nxt_sec = step_sec;
				nxt_ns  = step_ns;
			end else if (enable_ff) begin
				nxt_sec = adv_sec;
				nxt_ns  = adv_ns;
				if (cont_adj_ff) begin
					nxt_frac = rate_sign_ff ? frac_sum[ptcc_pkg::RATE_W-1:0]
						: frac_diff[ptcc_pkg::RATE_W-1:0];
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			freq_dis_ff  <= 1'b0;
			step_ff      <= 1'b0;
			step_dir_ff  <= 1'b0;
			snap_ff      <= 1'b0;
			load_ff      <= 1'b0;
			cont_adj_ff  <= 1'b0;
			enable_ff    <= 1'b0;
			clr_ff       <= 1'b0;
			h_phase_ff   <= 3'h0;
			h_ns_ff      <= 32'h0000_0000;
			h_sec_ff     <= 32'h0000_0000;
			rate_sign_ff <= 1'b0;
			temp_adj_ff  <= 1'b0;
			rate_ff      <= '0;
			sec_ff       <= 32'h0000_0000;
			ns_ff        <= 32'h0000_0000;
			frac_ff      <= '0;
			div_ff       <= 1'b0;
			rdata_ff     <= ptcc_pkg::RESET_WORD;
			rvalid_ff    <= 1'b0;
			tick_out_ff  <= 1'b0;
			follow_ff    <= 1'b1;
		end else begin
			freq_dis_ff  <= nxt_freq_dis;
			step_ff      <= nxt_step;
			step_dir_ff  <= nxt_step_dir;
			snap_ff      <= nxt_snap;
			load_ff      <= nxt_load;
			cont_adj_ff  <= nxt_cont_adj;
			enable_ff    <= nxt_enable;
			clr_ff       <= nxt_clr;
			h_phase_ff   <= nxt_h_phase;
			h_ns_ff      <= nxt_h_ns;
			h_sec_ff     <= nxt_h_sec;
			rate_sign_ff <= nxt_rate_sign;
			temp_adj_ff  <= nxt_temp_adj;
			rate_ff      <= nxt_rate;
			sec_ff       <= nxt_sec;
			ns_ff        <= nxt_ns;
			frac_ff      <= nxt_frac;
			div_ff       <= nxt_div;
			rdata_ff     <= nxt_rdata;
			rvalid_ff    <= nxt_rvalid;
			tick_out_ff  <= nxt_tick_out;
			follow_ff    <= nxt_follow;
		end
	end

	assign reg_rdata        = rdata_ff;
	assign reg_rdata_valid  = rvalid_ff;
	assign rtc_sec          = sec_ff;
	assign rtc_ns           = ns_ff;
	assign rtc_tick         = tick_out_ff;
	assign freq_corr_follow = follow_ff;
endmodule
`default_nettype wire

//--- verilog/ptcc_pkg.sv
// Register map, field positions and timing constants for the time clock control block
package ptcc_pkg;
	localparam logic [15:0] ADDR_CTRL     = 16'h0500;
	localparam logic [15:0] ADDR_PHASE    = 16'h0502;
	localparam logic [15:0] ADDR_NS_HI    = 16'h0504;
	localparam logic [15:0] ADDR_NS_LO    = 16'h0506;
	localparam logic [15:0] ADDR_SEC_HI   = 16'h0508;
	localparam logic [15:0] ADDR_SEC_LO   = 16'h050A;
	localparam logic [15:0] ADDR_RATE_HI  = 16'h050C;
	localparam logic [15:0] ADDR_RATE_LO  = 16'h050E;

	localparam int BIT_FREQ_DIS  = 15;
	localparam int BIT_STEP      = 6;
	localparam int BIT_STEP_DIR  = 5;
	localparam int BIT_SNAP      = 4;
	localparam int BIT_LOAD      = 3;
	localparam int BIT_CONT_ADJ  = 2;
	localparam int BIT_ENABLE    = 1;
	localparam int BIT_RESET     = 0;
	localparam int BIT_RATE_SIGN = 15;
	localparam int BIT_TEMP_ADJ  = 14;
	localparam int RATE_HI_W     = 14;
	localparam int RATE_W        = 30;
	localparam int PHASE_W       = 3;

	localparam logic [2:0]  PHASE_MAX    = 3'h4;
	localparam logic [15:0] RESET_WORD   = 16'h0000;
	localparam logic [32:0] NS_PER_SEC   = 33'h0_3B9A_CA00;
	localparam int          REF_PERIOD_NS = 40;
	localparam int          SYS_PERIOD_NS = 20;
	localparam int          SYS_PER_TICK  = REF_PERIOD_NS / SYS_PERIOD_NS;
	localparam logic [31:0] NS_PER_TICK   = 32'(REF_PERIOD_NS);
endpackage

//--- verilog/ptcc_time_add.sv
// Adds or subtracts a nanosecond amount to a seconds and nanoseconds time value
`timescale 1ns/1ps
`default_nettype none
module ptcc_time_add (
	input  wire logic [31:0] sec_in,
	input  wire logic [31:0] ns_in,
	input  wire logic [31:0] delta,
	input  wire logic        add,
	output logic      [31:0] sec_out,
	output logic      [31:0] ns_out
);
	logic [32:0] sum;
	logic [32:0] diff;

	// Delta is assumed below one second, so one wrap is enough
	always_comb begin
		sum  = {1'b0, ns_in} + {1'b0, delta};
		diff = {1'b0, ns_in} - {1'b0, delta};
		if (add) begin
			if (sum >= ptcc_pkg::NS_PER_SEC) begin
				ns_out  = 32'(sum - ptcc_pkg::NS_PER_SEC);
				sec_out = sec_in + 32'h0000_0001;
			end else begin
				ns_out  = sum[31:0];
				sec_out = sec_in;
			end
		end else begin
			if (diff[32]) begin
				ns_out  = 32'(diff + ptcc_pkg::NS_PER_SEC);
				sec_out = sec_in - 32'h0000_0001;
			end else begin
				ns_out  = diff[31:0];
				sec_out = sec_in;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/ptcc_host.sv
// Host software model that writes and reads the control registers
`timescale 1ns/1ps
`default_nettype none
module ptcc_host (
	input  wire logic        ref_clk,
	input  wire logic [15:0] reg_rdata,
	output var  logic [15:0] reg_addr = 16'hFFFF,
	output var  logic [15:0] reg_wdata = 16'h0000,
	output var  logic        reg_wr = 1'b0,
	output var  logic        reg_rd = 1'b0
);
	// Released lines show the inverse of the last value
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		{reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(negedge ref_clk);
		{reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge ref_clk);
		{reg_addr, reg_rd} = {a, 1'b1};
		@(negedge ref_clk);
		{reg_addr, reg_rd} = {~a, 1'b0};
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

//--- tb/ptcc_time_clock_ctrl_chk.sv
// Concurrent checks on the time clock control ports
`timescale 1ns/1ps
`default_nettype none
module ptcc_chk (
	input wire logic        ref_clk,
	input wire logic        rstn,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_rdata_valid,
	input wire logic [31:0] rtc_sec,
	input wire logic [31:0] rtc_ns,
	input wire logic        rtc_tick,
	input wire logic        freq_corr_follow
);
	logic [2:0] cnt_ff, nxt_cnt;
	logic       en_ff, nxt_en, ctrl_wr, quiet;
	assign ctrl_wr = reg_wr && reg_addr == ptcc_pkg::ADDR_CTRL;
	assign quiet   = cnt_ff == 3'h7;
	// Quiet once no control write for seven cycles, so pending actions are done
	always_comb begin
		nxt_cnt = ctrl_wr ? 3'h0 : cnt_ff + 3'(!quiet);
		nxt_en  = ctrl_wr ? reg_wdata[ptcc_pkg::BIT_ENABLE] : en_ff;
	end
	always_ff @(posedge ref_clk) begin
		cnt_ff <= rstn ? nxt_cnt : 3'h0;
		en_ff  <= rstn ? nxt_en : 1'b0;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence s_ctrl_settle;
		ctrl_wr ##1 !ctrl_wr [*2];
	endsequence
	sequence s_quiet_rd;
		reg_rd && reg_addr == ptcc_pkg::ADDR_CTRL && quiet;
	endsequence
	chk_freq_follow: assert property (s_ctrl_settle
		|-> freq_corr_follow == !$past(reg_wdata[ptcc_pkg::BIT_FREQ_DIS], 2))
		else $error("follow level wrong");
	chk_read_valid: assert property (reg_rdata_valid == $past(reg_rd))
		else $error("read valid wrong");
	chk_unmapped_zero: assert property (reg_rd && reg_addr[15:4] != 12'h050 |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	chk_action_cleared: assert property (s_quiet_rd |=> (reg_rdata & 16'h7FD9) == 16'h0000 && reg_rdata[15] != freq_corr_follow)
		else $error("control readback wrong");
	chk_phase_range: assert property (reg_rd && reg_addr == ptcc_pkg::ADDR_PHASE |=> reg_rdata <= 16'h0004)
		else $error("phase out of range");
	chk_tick_run: assert property (en_ff [*6] |-> rtc_tick || $past(rtc_tick))
		else $error("tick missing");
	chk_tick_gate: assert property (rtc_tick |-> en_ff || $past(en_ff) || $past(en_ff, 2) || $past(en_ff, 3))
		else $error("tick while stopped");
	chk_ns_advance: assert property ($changed(rtc_ns) && quiet && rtc_ns > $past(rtc_ns) |-> rtc_ns - $past(rtc_ns) inside {[39:41]})
		else $error("ns advance wrong");
	chk_sec_carry: assert property ($changed(rtc_sec) && quiet
		|-> rtc_sec == $past(rtc_sec) + 32'h0000_0001 && rtc_ns < 32'h0000_0029)
		else $error("second carry wrong");
endmodule
bind ptcc_time_clock_ctrl ptcc_chk u_chk (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.reg_rdata_valid(reg_rdata_valid), .rtc_sec(rtc_sec), .rtc_ns(rtc_ns), .rtc_tick(rtc_tick),
	.freq_corr_follow(freq_corr_follow));
`default_nettype wire

//--- tb/tb_precision_time_clock_control.sv
// Self-checking bench for the time clock control block
`timescale 1ns/1ps
`default_nettype none
module tb_precision_time_clock_control;
	logic        ref_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, x;
	logic        reg_wr, reg_rd, reg_rdata_valid, rtc_tick, freq_corr_follow, a;
	logic [31:0] rtc_sec, rtc_ns, s0, n0, dl;
	logic [63:0] e;
	int          fail_count = 0;
	int          samples_checked = 0;
	int          ticks = 0;
	int          n;

	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (rtc_tick === 1'b1) ticks <= ticks + 1;

	ptcc_host host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
	ptcc_time_clock_ctrl dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rdata_valid(reg_rdata_valid), .rtc_sec(rtc_sec), .rtc_ns(rtc_ns),
		.rtc_tick(rtc_tick), .freq_corr_follow(freq_corr_follow));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("Checks %0d, errors %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic rchk(input logic [15:0] ad, input logic [15:0] ex);
		host.rd(ad, x);
		chk({16'h0000, x}, {16'h0000, ex});
	endtask
	task automatic hold(input logic [31:0] s, input logic [31:0] t);
		host.wr(16'h0504, t[31:16]);
		host.wr(16'h0506, t[15:0]);
		host.wr(16'h0508, s[31:16]);
		host.wr(16'h050A, s[15:0]);
	endtask
	task automatic ctl(input logic [15:0] d);
		host.wr(16'h0500, d);
		repeat (4) @(negedge ref_clk);
	endtask
	// Time after adding or subtracting d nanoseconds
	function automatic logic [63:0] tadd(logic [31:0] s, logic [31:0] t, logic [31:0] d, logic up);
		logic [32:0] r;
		r = up ? 33'(t) + 33'(d) : 33'(t) + ptcc_pkg::NS_PER_SEC - 33'(d);
		if (r >= ptcc_pkg::NS_PER_SEC)
			return {s + 32'(up), 32'(r - ptcc_pkg::NS_PER_SEC)};
		return {s - 32'(!up), r[31:0]};
	endfunction

	initial begin
		repeat (90000) @(posedge ref_clk);
		fail_count++;
		finish_test;
	end

	initial begin
		n = $urandom(32'hDAAC);
		repeat (5) @(negedge ref_clk);
		rstn = 1'b1;
		chk(32'(freq_corr_follow), 32'h1);
		rchk(16'h0500, 16'h0000);
		rchk(16'h0510, 16'h0000);
		ctl(16'hFFA4);
		chk(32'(freq_corr_follow), 32'h0);
		rchk(16'h0500, 16'h8024);
		for (int i = 0; i < 8; i++) begin
			host.wr(16'h0502, 16'(i));
			rchk(16'h0502, 16'(i < 5 ? i : 4));
		end
		for (int i = 0; i < 8; i++) begin
			s0 = $urandom;
			n0 = i == 0 ? 32'h3B9A_C9FF : i == 1 ? 32'h0000_0000 : $urandom % 32'h3B9A_CA00;
			dl = i < 2 ? 32'h0000_0001 : $urandom % 32'h3B9A_CA00;
			a = i == 0 ? 1'b1 : i == 1 ? 1'b0 : 1'($urandom);
			hold(s0, n0);
			ctl(16'h0008);
			chk(rtc_sec, s0);
			chk(rtc_ns, n0);
			chk(32'(freq_corr_follow), 32'h1);
			host.wr(16'h0504, dl[31:16]);
			host.wr(16'h0506, dl[15:0]);
			ctl({9'h000, 1'b1, a, 5'h00});
			e = tadd(s0, n0, dl, a);
			chk(rtc_sec, e[63:32]);
			chk(rtc_ns, e[31:0]);
			rchk(16'h0500, {10'h000, a, 5'h00});
			ctl(16'h0010);
			rchk(16'h0504, e[31:16]);
			rchk(16'h0506, e[15:0]);
			rchk(16'h0508, e[63:48]);
			rchk(16'h050A, e[47:32]);
			rchk(16'h0502, 16'h0000);
		end
		for (int i = 0; i < 2; i++) begin
			host.wr(16'h050C, {i[0], 15'h2000});
			host.wr(16'h050E, 16'h0000);
			rchk(16'h050C, {i[0], 15'h2000});
			rchk(16'h050E, 16'h0000);
			ctl(16'h0001);
			chk(rtc_sec, 32'h0);
			chk(rtc_ns, 32'h0);
			hold(32'h0000_0005, 32'h3B9A_C230);
			ctl(16'h0008);
			n = ticks;
			ctl(16'h0006);
			repeat (200) @(negedge ref_clk);
			ctl(16'h0000);
			n = ticks - n;
			e = tadd(32'h0000_0005, 32'h3B9A_C230,
				32'(i ? 40 * n + n / 2 : 40 * n - (n + 1) / 2), 1'b1);
			chk(rtc_sec, e[63:32]);
			chk(rtc_ns, e[31:0]);
			repeat (10) @(negedge ref_clk);
			chk(rtc_ns, e[31:0]);
		end
		finish_test;
	end
endmodule
`default_nettype wire
